// file: src/aux_watchdog_cfg.svh
`ifndef AUX_WATCHDOG_CFG_SVH
`define AUX_WATCHDOG_CFG_SVH

// Register offsets in the auxiliary logical device
`define WD_REG_UNITS      8'hf1
`define WD_REG_PERIOD     8'hf2
`define WD_REG_SOURCES    8'hf3
`define WD_REG_CTRL       8'hf4
`define WD_REG_INT_STATUS 8'hf5
`define WD_REG_INT_CLEAR  8'hf6
`define WD_REG_INT_ENABLE 8'hf7

// Field positions
`define WD_UNITS_BIT      7
`define WD_SRC_GAME_BIT   0
`define WD_SRC_KBD_BIT    1
`define WD_SRC_MOUSE_BIT  2
`define WD_MAP_HI         7
`define WD_MAP_LO         4
`define WD_CTRL_FLAG_BIT  0
`define WD_CTRL_FORCE_BIT 2
`define WD_CTRL_LINE_BIT  3
`define WD_EV_COUNT_BIT   0
`define WD_EV_SOFT_BIT    1
`define WD_EV_LINE_BIT    2

// Values
`define WD_RST_BYTE       8'h00
`define WD_RST_EVENTS     3'h0
`define WD_RST_LINES      16'h0000
`define WD_PERIOD_OFF     8'h00
`define WD_COUNT_LAST     8'h01
`define WD_MAP_OFF        4'h0
`define WD_MAP_INVALID    4'h2
`define WD_IRQ_ONE        16'h0001
`define WD_SRC_KEEP       8'hf7

// Timing
`define WD_CLK_PERIOD_NS  20
`define WD_SECOND_NS      1000000000
`define WD_SECS_PER_MIN   60
`define WD_CLKS_PER_SEC   (`WD_SECOND_NS / `WD_CLK_PERIOD_NS)

`endif

// file: src/aux_watchdog_pkg.sv
package aux_watchdog_pkg;

    typedef enum logic [2:0] {
        WD_IDLE    = 3'b001,
        WD_COUNT   = 3'b010,
        WD_EXPIRED = 3'b100
    } wd_state_t;

    typedef logic [7:0] wd_byte_t;

endpackage

// file: src/wdt_edge_pulse.sv
`timescale 1ns/1ps

module wdt_edge_pulse (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_level,
    input  wire logic i_enable,
    output logic      o_pulse
);

    logic level_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= i_level;
        end
    end

    // One pulse per rising edge, however long the level stays high
    assign o_pulse = i_enable & i_level & ~level_q;

endmodule

// file: src/wdt_unit_tick.sv
`timescale 1ns/1ps
`include "aux_watchdog_cfg.svh"

module wdt_unit_tick #(
    parameter int CLKS_PER_SEC = `WD_CLKS_PER_SEC,
    parameter int SECS_PER_MIN = `WD_SECS_PER_MIN
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_restart,
    input  wire logic i_seconds,
    output logic      o_tick
);

    localparam int CW = $clog2(CLKS_PER_SEC);
    localparam int MW = $clog2(SECS_PER_MIN);

    if (CLKS_PER_SEC < 2 || SECS_PER_MIN < 2) begin : g_bad
        $error("wdt_unit_tick: counts must be at least 2");
    end

    logic [CW-1:0] cyc_q;
    logic [MW-1:0] sec_q;
    logic          sec_tick;
    logic          min_tick;

    assign sec_tick = (cyc_q == CW'(CLKS_PER_SEC - 1));
    assign min_tick = sec_tick && (sec_q == MW'(SECS_PER_MIN - 1));

    // Restart clears the prescaler so a fresh period gets whole units
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || i_restart) begin
            cyc_q <= '0;
        end else if (sec_tick) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_q + CW'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || i_restart) begin
            sec_q <= '0;
        end else if (min_tick) begin
            sec_q <= '0;
        end else if (sec_tick) begin
            sec_q <= sec_q + MW'(1);
        end
    end

    assign o_tick = i_seconds ? sec_tick : min_tick;

    a_minute_tick: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_tick && !i_seconds) |-> (sec_tick && sec_q == MW'(SECS_PER_MIN - 1)))
        else $error("minute tick without last second");

endmodule

// file: src/aux_watchdog_timer.sv
// What this block does
// - Bit 7 of the units register picks minutes when 0 (reset) and seconds when 1.
// - A period of zero keeps the watchdog disabled and no count time-out occurs.
// - A nonzero period is an unsigned count of 1 to 255 units before time-out.
// - With source bit 0 set, each game-port access restarts the count, else ignored.
// - With source bit 1 set, each keyboard interrupt restarts the count, else ignored.
// - With source bit 2 set, each mouse interrupt restarts the count, else ignored.
// - Source bits 7:4 name the IRQ line taking the time-out; 0000 is off, 0010 invalid.
// - Control bit 0 is a read/write flag that reads 1 after a time-out until software writes 0.
// - Writing 1 to control bit 2 forces a time-out and the bit clears itself.
// - With control bit 3 set, a rising edge on the reset-out line forces a time-out.
// - The software force still works while line forcing is enabled.
// - The reset-out line goes through an edge detector whose pulse is ORed with the force.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "aux_watchdog_cfg.svh"

module aux_watchdog_timer #(
    parameter int CLKS_PER_SEC = `WD_CLKS_PER_SEC
) (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_reset_n,
    input  wire logic [7:0]                i_addr,
    input  wire aux_watchdog_pkg::wd_byte_t i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output aux_watchdog_pkg::wd_byte_t     o_rdata,
    input  wire logic                      i_game_port_access,
    input  wire logic                      i_kbd_irq,
    input  wire logic                      i_mouse_irq,
    input  wire logic                      i_kbc_reset_out_line,
    output logic [15:0]                    o_irq_lines,
    output logic                           o_irq
);

    import aux_watchdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic      units_sec_q;
    wd_byte_t  period_q;
    wd_byte_t  sources_q;
    logic      line_en_q;
    logic      flag_q;
    wd_byte_t  count_q;
    wd_state_t state_q;
    logic [2:0] ev_status_q;
    logic [2:0] ev_enable_q;
    logic [15:0] irq_lines_q;
    wd_byte_t  rdata_q;

    logic       wr_units;
    logic       wr_period;
    logic       wr_sources;
    logic       wr_ctrl;
    logic       wr_ev_clear;
    logic       wr_ev_enable;
    logic       kbd_pulse;
    logic       mouse_pulse;
    logic       line_pulse;
    logic       game_restart;
    logic       restart;
    logic       reload;
    logic       tick;
    logic       soft_force;
    logic       force_evt;
    logic       count_evt;
    logic [3:0] irq_map;
    logic [2:0] ev_set;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    assign wr_units     = i_wr && hit(i_addr, `WD_REG_UNITS);
    assign wr_period    = i_wr && hit(i_addr, `WD_REG_PERIOD);
    assign wr_sources   = i_wr && hit(i_addr, `WD_REG_SOURCES);
    assign wr_ctrl      = i_wr && hit(i_addr, `WD_REG_CTRL);
    assign wr_ev_clear  = i_wr && hit(i_addr, `WD_REG_INT_CLEAR);
    assign wr_ev_enable = i_wr && hit(i_addr, `WD_REG_INT_ENABLE);

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            units_sec_q <= 1'b0;
        end else if (wr_units) begin
            units_sec_q <= i_wdata[`WD_UNITS_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            period_q <= `WD_RST_BYTE;
        end else if (wr_period) begin
            period_q <= i_wdata;
        end
    end

    // Bit 3 is reserved and never stored
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sources_q <= `WD_RST_BYTE;
        end else if (wr_sources) begin
            sources_q <= i_wdata & `WD_SRC_KEEP;
        end
    end

    // Upper control bits are not stored, so nonzero writes there do no harm
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            line_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            line_en_q <= i_wdata[`WD_CTRL_LINE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Restart and force sources

    wdt_edge_pulse u_kbd_edge (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_level   (i_kbd_irq),
        .i_enable  (sources_q[`WD_SRC_KBD_BIT]),
        .o_pulse   (kbd_pulse)
    );

    wdt_edge_pulse u_mouse_edge (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_level   (i_mouse_irq),
        .i_enable  (sources_q[`WD_SRC_MOUSE_BIT]),
        .o_pulse   (mouse_pulse)
    );

    wdt_edge_pulse u_line_edge (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_level   (i_kbc_reset_out_line),
        .i_enable  (line_en_q),
        .o_pulse   (line_pulse)
    );

    assign game_restart = i_game_port_access && sources_q[`WD_SRC_GAME_BIT];
    assign restart      = game_restart || kbd_pulse || mouse_pulse;
    assign reload       = wr_period || restart;

    // Force bit is never stored, which makes it self-clearing
    assign soft_force = wr_ctrl && i_wdata[`WD_CTRL_FORCE_BIT];
    assign force_evt  = soft_force || line_pulse;

    ////////////////////////////////////////////////////////////////////////////////
    // Unit prescaler and countdown

    wdt_unit_tick #(
        .CLKS_PER_SEC (CLKS_PER_SEC),
        .SECS_PER_MIN (`WD_SECS_PER_MIN)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_restart (reload),
        .i_seconds (units_sec_q),
        .o_tick    (tick)
    );

    assign count_evt = (state_q == WD_COUNT) && tick && !reload
                       && (period_q != `WD_PERIOD_OFF) && (count_q == `WD_COUNT_LAST);

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_q <= WD_IDLE;
            count_q <= `WD_RST_BYTE;
        end else if (wr_period) begin
            count_q <= i_wdata;
            state_q <= (i_wdata == `WD_PERIOD_OFF) ? WD_IDLE : WD_COUNT;
        end else if (period_q == `WD_PERIOD_OFF) begin
            state_q <= WD_IDLE;
        end else if (restart) begin
            count_q <= period_q;
            state_q <= WD_COUNT;
        end else begin
            unique case (state_q)
                WD_IDLE: begin
                    state_q <= WD_IDLE;
                end
                WD_COUNT: begin
                    if (count_evt) begin
                        count_q <= `WD_RST_BYTE;
                        state_q <= WD_EXPIRED;
                    end else if (tick) begin
                        count_q <= count_q - `WD_COUNT_LAST;
                    end
                end
                WD_EXPIRED: begin
                    state_q <= WD_EXPIRED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time-out flag and IRQ routing

    // A time-out in the same cycle as a software clear keeps the flag set
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            flag_q <= 1'b0;
        end else if (count_evt || force_evt) begin
            flag_q <= 1'b1;
        end else if (wr_ctrl) begin
            flag_q <= i_wdata[`WD_CTRL_FLAG_BIT];
        end
    end

    assign irq_map = sources_q[`WD_MAP_HI:`WD_MAP_LO];

    // Invalid code 0010 routes nowhere rather than to a line in use elsewhere
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            irq_lines_q <= `WD_RST_LINES;
        end else if (flag_q && irq_map != `WD_MAP_OFF && irq_map != `WD_MAP_INVALID) begin
            irq_lines_q <= `WD_IRQ_ONE << irq_map;
        end else begin
            irq_lines_q <= `WD_RST_LINES;
        end
    end

    assign o_irq_lines = irq_lines_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Event status, clear and enable

    assign ev_set = {line_pulse, soft_force, count_evt};

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ev_status_q <= `WD_RST_EVENTS;
        end else if (wr_ev_clear) begin
            ev_status_q <= (ev_status_q & ~i_wdata[`WD_EV_LINE_BIT:`WD_EV_COUNT_BIT]) | ev_set;
        end else begin
            ev_status_q <= ev_status_q | ev_set;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ev_enable_q <= `WD_RST_EVENTS;
        end else if (wr_ev_enable) begin
            ev_enable_q <= i_wdata[`WD_EV_LINE_BIT:`WD_EV_COUNT_BIT];
        end
    end

    assign o_irq = |(ev_status_q & ev_enable_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rdata_q <= `WD_RST_BYTE;
        end else if (i_rd) begin
            rdata_q <= `WD_RST_BYTE;
            if (hit(i_addr, `WD_REG_UNITS)) begin
                rdata_q[`WD_UNITS_BIT] <= units_sec_q;
            end
            if (hit(i_addr, `WD_REG_PERIOD)) begin
                rdata_q <= period_q;
            end
            if (hit(i_addr, `WD_REG_SOURCES)) begin
                rdata_q <= sources_q;
            end
            if (hit(i_addr, `WD_REG_CTRL)) begin
                rdata_q[`WD_CTRL_FLAG_BIT] <= flag_q;
                rdata_q[`WD_CTRL_LINE_BIT] <= line_en_q;
            end
            if (hit(i_addr, `WD_REG_INT_STATUS)) begin
                rdata_q[`WD_EV_LINE_BIT:`WD_EV_COUNT_BIT] <= ev_status_q;
            end
            if (hit(i_addr, `WD_REG_INT_ENABLE)) begin
                rdata_q[`WD_EV_LINE_BIT:`WD_EV_COUNT_BIT] <= ev_enable_q;
            end
        end else begin
            rdata_q <= `WD_RST_BYTE;
        end
    end

    assign o_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    a_zero_period_quiet: assert property (
        (period_q == `WD_PERIOD_OFF && !wr_period) |=> (state_q == WD_IDLE && !count_evt))
        else $error("count time-out with zero period");

    a_period_reload: assert property (
        wr_period |=> (count_q == $past(i_wdata)))
        else $error("period write did not load count");

    a_game_restart: assert property (
        (game_restart && !wr_period && period_q != `WD_PERIOD_OFF) |=> (count_q == period_q))
        else $error("game access did not restart count");

    a_kbd_restart: assert property (
        ($rose(i_kbd_irq) && sources_q[`WD_SRC_KBD_BIT] && !wr_period
         && period_q != `WD_PERIOD_OFF) |=> (count_q == period_q && state_q == WD_COUNT))
        else $error("keyboard irq did not restart count");

    a_mouse_restart: assert property (
        ($rose(i_mouse_irq) && sources_q[`WD_SRC_MOUSE_BIT] && !wr_period
         && period_q != `WD_PERIOD_OFF) |=> (count_q == period_q && state_q == WD_COUNT))
        else $error("mouse irq did not restart count");

    a_count_expire: assert property (
        count_evt |=> (flag_q && state_q == WD_EXPIRED))
        else $error("count end did not set flag");

    a_soft_force: assert property (
        soft_force |=> (flag_q && ev_status_q[`WD_EV_SOFT_BIT]))
        else $error("force bit did not set flag");

    a_line_force: assert property (
        ($rose(i_kbc_reset_out_line) && line_en_q) |=> flag_q)
        else $error("line edge did not force time-out");

    a_line_single: assert property (
        line_pulse |=> !line_pulse)
        else $error("line pulse longer than one cycle");

    a_irq_route: assert property (
        (flag_q && irq_map != `WD_MAP_OFF && irq_map != `WD_MAP_INVALID)
        |=> (o_irq_lines == (`WD_IRQ_ONE << $past(irq_map))))
        else $error("irq not routed to mapped line");

    a_irq_invalid: assert property (
        (irq_map == `WD_MAP_INVALID || irq_map == `WD_MAP_OFF) && !wr_sources
        |=> (o_irq_lines == `WD_RST_LINES))
        else $error("irq routed for off or invalid map");

    c_count_timeout: cover property (count_evt ##[1:4] o_irq_lines != `WD_RST_LINES);
    c_line_timeout:  cover property (line_pulse ##1 flag_q);
    c_restart_count: cover property (restart && state_q == WD_COUNT);

endmodule

// file: bench/tb.sv
`timescale 1ns/1ps

module tb;
    import aux_watchdog_pkg::*;

    // Shortened second so minute and 255-unit runs stay brief
    localparam int CPS = 4;

    logic        i_clk_sys;
    logic        i_reset_n;
    logic [7:0]  i_addr;
    wd_byte_t    i_wdata;
    logic        i_wr;
    logic        i_rd;
    wd_byte_t    o_rdata;
    logic        i_game_port_access;
    logic        i_kbd_irq;
    logic        i_mouse_irq;
    logic        i_kbc_reset_out_line;
    logic [15:0] o_irq_lines;
    logic        o_irq;
    int          num_errors;
    int          checked;

    aux_watchdog_timer #(.CLKS_PER_SEC(CPS)) uut (
        .i_clk_sys            (i_clk_sys),
        .i_reset_n            (i_reset_n),
        .i_addr               (i_addr),
        .i_wdata              (i_wdata),
        .i_wr                 (i_wr),
        .i_rd                 (i_rd),
        .o_rdata              (o_rdata),
        .i_game_port_access   (i_game_port_access),
        .i_kbd_irq            (i_kbd_irq),
        .i_mouse_irq          (i_mouse_irq),
        .i_kbc_reset_out_line (i_kbc_reset_out_line),
        .o_irq_lines          (o_irq_lines),
        .o_irq                (o_irq)
    );

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        check({8'h00, o_rdata}, {8'h00, exp});
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge i_clk_sys);
        i_game_port_access <= m[0];
        i_kbd_irq          <= m[1];
        i_mouse_irq        <= m[2];
        @(posedge i_clk_sys);
        i_game_port_access <= 1'b0;
        i_kbd_irq          <= 1'b0;
        i_mouse_irq        <= 1'b0;
    endtask

    task automatic clr();
        wr(8'hf6, 8'h07);
        wr(8'hf4, 8'h00);
    endtask

    // Cycles from the period write to the interrupt; one cycle of slack either way
    task automatic timed(input logic [7:0] units, input logic [7:0] per, input int len);
        int n;
        n = 0;
        clr();
        wr(8'hf1, units);
        wr(8'hf2, per);
        while (n <= len + 2 && o_irq !== 1'b1) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        if (o_irq !== 1'b1) begin
            num_errors++;
            final_report();
        end else begin
            check(16'(n >= len - 1 && n <= len + 1), 16'h0001);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        i_reset_n            = 1'b0;
        i_addr               = 8'h00;
        i_wdata              = 8'h00;
        i_wr                 = 1'b0;
        i_rd                 = 1'b0;
        i_game_port_access   = 1'b0;
        i_kbd_irq            = 1'b0;
        i_mouse_irq          = 1'b0;
        i_kbc_reset_out_line = 1'b0;
        num_errors           = 0;
        checked              = 0;
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        idle(1);
        for (int a = 8'hf1; a <= 8'hf5; a++) begin
            rd(8'(a), 8'h00);
        end
        rd(8'hf7, 8'h00);
        rd(8'hf0, 8'h00);
        check(o_irq_lines, 16'h0000);
        check({15'h0000, o_irq}, 16'h0000);
        wr(8'hf1, 8'hff);
        rd(8'hf1, 8'h80);
        wr(8'hf7, 8'h07);
        wr(8'hf3, 8'h30);

        // Counted expiries in seconds, at the top count, and in minutes
        timed(8'h80, 8'h02, 2 * CPS);
        idle(2);
        check(o_irq_lines, 16'h0008);
        rd(8'hf5, 8'h01);
        rd(8'hf4, 8'h01);
        timed(8'h80, 8'hff, 255 * CPS);
        timed(8'h00, 8'h01, 60 * CPS);

        // Zero period never expires, even past a full minute
        clr();
        wr(8'hf2, 8'h00);
        idle(300);
        check({15'h0000, o_irq}, 16'h0000);
        rd(8'hf4, 8'h00);

        // Each enabled source restarts the count; disabled sources do not
        wr(8'hf1, 8'h80);
        for (int s = 0; s < 3; s++) begin
            clr();
            wr(8'hf3, 8'h30 | (8'h01 << s));
            wr(8'hf2, 8'h03);
            idle(8);
            pulse(3'b001 << s);
            idle(8);
            check({15'h0000, o_irq}, 16'h0000);
            idle(8);
            check({15'h0000, o_irq}, 16'h0001);
        end
        clr();
        wr(8'hf3, 8'h30);
        wr(8'hf2, 8'h03);
        idle(8);
        pulse(3'b111);
        idle(5);
        check({15'h0000, o_irq}, 16'h0001);

        // Reset-out line: ignored when disabled, one event per rising edge
        clr();
        wr(8'hf2, 8'h00);
        i_kbc_reset_out_line <= 1'b1;
        idle(6);
        rd(8'hf5, 8'h00);
        i_kbc_reset_out_line <= 1'b0;
        wr(8'hf4, 8'h08);
        i_kbc_reset_out_line <= 1'b1;
        idle(4);
        rd(8'hf5, 8'h04);
        rd(8'hf4, 8'h09);
        wr(8'hf6, 8'h07);
        wr(8'hf4, 8'h08);
        idle(6);
        rd(8'hf5, 8'h00);
        rd(8'hf4, 8'h08);
        i_kbc_reset_out_line <= 1'b0;
        wr(8'hf4, 8'h0c);
        rd(8'hf4, 8'h09);
        rd(8'hf5, 8'h02);

        // Interrupt masking and clearing
        wr(8'hf7, 8'h00);
        idle(1);
        check({15'h0000, o_irq}, 16'h0000);
        wr(8'hf7, 8'h02);
        idle(1);
        check({15'h0000, o_irq}, 16'h0001);
        wr(8'hf6, 8'h02);
        idle(1);
        check({15'h0000, o_irq}, 16'h0000);

        // Every routing code while the flag is set
        for (int m = 0; m < 16; m++) begin
            wr(8'hf3, 8'(m << 4));
            idle(2);
            check(o_irq_lines, (m == 0 || m == 2) ? 16'h0000 : 16'h0001 << m);
        end
        wr(8'hf4, 8'h08);
        idle(2);
        check(o_irq_lines, 16'h0000);
        wr(8'hf4, 8'h01);
        rd(8'hf4, 8'h01);
        final_report();
    end

endmodule
